// ===== rtl/wdslp_pkg.sv
package wdslp_pkg;
    // register byte addresses on the apb bus
    localparam logic [7:0] addr_sw_control = 8'h00;
    localparam logic [7:0] addr_reset_cause = 8'h04;
    localparam logic [7:0] addr_config_high = 8'h08;
    localparam logic [7:0] addr_wake_control = 8'h0c;
    // software control fields
    localparam int sw_enable_bit = 0;
    localparam logic [7:0] sw_control_reset = 8'h00;
    // configuration byte fields
    localparam int cfg_enable_bit = 0;
    localparam int cfg_ps_lsb = 1;
    localparam int cfg_ps_width = 3;
    // reset cause fields
    localparam int rc_pd_bit = 3;
    localparam int rc_to_bit = 4;
    // wake control fields: bit 0 selects crystal mode start-up delay
    localparam int wk_crystal_bit = 0;
    // start-up delay in oscillator periods
    localparam int osc_startup_periods = 1024;
    // number of wake-capable interrupt sources
    localparam int wake_sources = 14;
    typedef enum logic [3:0] {
        wdslp_run_type_e = 4'h1,
        wdslp_sleep_type_e = 4'h2,
        wdslp_start_type_e = 4'h4,
        wdslp_reset_type_e = 4'h8
    } wdslp_state_type;
endpackage

// ===== rtl/wdslp_top.sv
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module wdslp_top #(
    parameter int base_width = 7,
    parameter int startup_cycles = wdslp_pkg::osc_startup_periods
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wdt_rc_clk,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] config_high_value,
    input wire logic clear_watchdog_instr,
    input wire logic sleep_instr,
    input wire logic master_clear_pin,
    input wire logic [wdslp_pkg::wake_sources-1:0] irq_flags,
    input wire logic [wdslp_pkg::wake_sources-1:0] irq_enables,
    input wire logic global_interrupt_enable,
    output logic sleeping,
    output logic osc_driver_on,
    output logic io_hold,
    output logic core_stall,
    output logic vector_after_next,
    output logic device_reset,
    output logic watchdog_reset_pulse
);
    localparam int ps_max = (1 << wdslp_pkg::cfg_ps_width) - 1;
    localparam int cnt_width = base_width + ps_max + 1;
    // sized so the start-up count always fits, whatever the parameter is
    localparam int startup_width = $clog2(startup_cycles + 2);

    logic [7:0] sw_control_reg;
    logic timeout_flag_n_reg;
    logic powerdown_flag_n_reg;
    logic [4:0] reset_cause_value;
    logic [7:0] wake_control_reg;
    logic [startup_width-1:0] startup_reg;
    logic vector_reg;
    wdslp_pkg::wdslp_state_type state_reg;

    logic cfg_enable;
    logic [wdslp_pkg::cfg_ps_width-1:0] ps_sel;
    logic wdt_enabled;
    logic enabled_pending;
    logic sleep_taken;
    logic wdt_clear_req;

    // clear events cross to the rc domain as a toggle
    logic clear_toggle_reg;
    logic [2:0] clr_sync_rc_reg;
    logic en_sync1_reg;
    logic en_sync2_reg;
    logic [cnt_width-1:0] wdt_count_reg;
    logic timeout_toggle_reg;
    logic [2:0] to_sync_reg;
    logic timeout_evt;

    assign cfg_enable = config_high_value[wdslp_pkg::cfg_enable_bit];
    assign ps_sel = config_high_value[wdslp_pkg::cfg_ps_lsb +: wdslp_pkg::cfg_ps_width];
    assign wdt_enabled = cfg_enable | sw_control_reg[wdslp_pkg::sw_enable_bit];
    // wake is gated by each source enable only, never by the global enable
    logic [wdslp_pkg::wake_sources-1:0] wake_qualified;
    for (genvar i = 0; i < wdslp_pkg::wake_sources; i++) begin : gen_wake_source
        assign wake_qualified[i] = irq_flags[i] & irq_enables[i];
    end
    assign enabled_pending = |wake_qualified;
    assign sleep_taken = sleep_instr & (state_reg == wdslp_pkg::wdslp_run_type_e)
        & ~enabled_pending;
    assign wdt_clear_req = (clear_watchdog_instr & (state_reg == wdslp_pkg::wdslp_run_type_e))
        | sleep_taken;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clear_toggle_reg <= 1'b0;
        end else if (wdt_clear_req) begin
            clear_toggle_reg <= ~clear_toggle_reg;
        end
    end

    // rc domain: keeps counting while the main oscillator is stopped
    always_ff @(posedge wdt_rc_clk or negedge presetn) begin
        if (!presetn) begin
            clr_sync_rc_reg <= 3'h0;
        end else begin
            clr_sync_rc_reg <= {clr_sync_rc_reg[1:0], clear_toggle_reg};
        end
    end

    // the enable is a level, so a plain two-stage synchroniser is enough
    always_ff @(posedge wdt_rc_clk or negedge presetn) begin
        if (!presetn) begin
            en_sync1_reg <= 1'b0;
            en_sync2_reg <= 1'b0;
        end else begin
            en_sync1_reg <= wdt_enabled;
            en_sync2_reg <= en_sync1_reg;
        end
    end

    logic wdt_clear_seen;
    logic wdt_timeout_hit;
    assign wdt_clear_seen = clr_sync_rc_reg[2] ^ clr_sync_rc_reg[1];
    // the selected count bit is the postscaler output: base period times 2**ps_sel
    assign wdt_timeout_hit = wdt_count_reg[base_width + int'(ps_sel)];

    // one counter covers base period and postscaler; only the count clears,
    // the postscale selection stays as programmed
    always_ff @(posedge wdt_rc_clk or negedge presetn) begin
        if (!presetn) begin
            wdt_count_reg <= '0;
        end else if (wdt_clear_seen) begin
            wdt_count_reg <= '0;
        end else if (!en_sync2_reg) begin
            wdt_count_reg <= '0;
        end else if (wdt_timeout_hit) begin
            wdt_count_reg <= '0;
        end else begin
            wdt_count_reg <= wdt_count_reg + 1'b1;
        end
    end

    // time-outs cross back to pclk as a toggle, one flip per time-out
    always_ff @(posedge wdt_rc_clk or negedge presetn) begin
        if (!presetn) begin
            timeout_toggle_reg <= 1'b0;
        end else if (!wdt_clear_seen && en_sync2_reg && wdt_timeout_hit) begin
            timeout_toggle_reg <= ~timeout_toggle_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            to_sync_reg <= 3'h0;
        end else begin
            to_sync_reg <= {to_sync_reg[1:0], timeout_toggle_reg};
        end
    end
    assign timeout_evt = to_sync_reg[2] ^ to_sync_reg[1];

    // sleep / wake sequencer
    wdslp_pkg::wdslp_state_type state_next;
    logic [startup_width-1:0] startup_next;
    logic vector_next;

    always_comb begin
        state_next = state_reg;
        startup_next = startup_reg;
        vector_next = 1'b0;
        case (state_reg)
            wdslp_pkg::wdslp_run_type_e: begin
                if (timeout_evt) begin
                    // an awake time-out wins over a sleep issued in the same cycle
                    state_next = wdslp_pkg::wdslp_reset_type_e;
                end else if (sleep_taken) begin
                    state_next = wdslp_pkg::wdslp_sleep_type_e;
                end
            end
            wdslp_pkg::wdslp_sleep_type_e: begin
                if (master_clear_pin) begin
                    state_next = wdslp_pkg::wdslp_reset_type_e;
                end else if (timeout_evt || enabled_pending) begin
                    state_next = wdslp_pkg::wdslp_start_type_e;
                    if (wake_control_reg[wdslp_pkg::wk_crystal_bit]) begin
                        startup_next = startup_width'(startup_cycles);
                    end else begin
                        startup_next = '0;
                    end
                end
            end
            wdslp_pkg::wdslp_start_type_e: begin
                if (master_clear_pin) begin
                    state_next = wdslp_pkg::wdslp_reset_type_e;
                end else if (startup_reg == '0) begin
                    state_next = wdslp_pkg::wdslp_run_type_e;
                    // the prefetched next instruction runs first, then the vector
                    vector_next = enabled_pending & global_interrupt_enable;
                end else begin
                    startup_next = startup_reg - 1'b1;
                end
            end
            wdslp_pkg::wdslp_reset_type_e: begin
                state_next = wdslp_pkg::wdslp_run_type_e;
            end
            default: begin
                state_next = wdslp_pkg::wdslp_run_type_e;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= wdslp_pkg::wdslp_run_type_e;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            startup_reg <= '0;
        end else begin
            startup_reg <= startup_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vector_reg <= 1'b0;
        end else begin
            vector_reg <= vector_next;
        end
    end

    // status decoded per state; pins and core stay held until start-up ends
    always_comb begin
        sleeping = 1'b0;
        osc_driver_on = 1'b1;
        io_hold = 1'b0;
        device_reset = 1'b0;
        case (state_reg)
            wdslp_pkg::wdslp_sleep_type_e: begin
                sleeping = 1'b1;
                osc_driver_on = 1'b0;
                io_hold = 1'b1;
            end
            wdslp_pkg::wdslp_start_type_e: begin
                io_hold = 1'b1;
            end
            wdslp_pkg::wdslp_reset_type_e: begin
                device_reset = 1'b1;
            end
            default: begin
                device_reset = 1'b0;
            end
        endcase
    end

    assign core_stall = io_hold;
    assign vector_after_next = vector_reg;
    assign watchdog_reset_pulse = device_reset & ~timeout_flag_n_reg;

    // reset cause flags are active low; a time-out beats a sleep in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_flag_n_reg <= 1'b1;
        end else if (timeout_evt) begin
            timeout_flag_n_reg <= 1'b0;
        end else if (sleep_taken) begin
            timeout_flag_n_reg <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            powerdown_flag_n_reg <= 1'b1;
        end else if (sleep_taken && !timeout_evt) begin
            powerdown_flag_n_reg <= 1'b0;
        end
    end

    always_comb begin
        reset_cause_value = '0;
        reset_cause_value[wdslp_pkg::rc_to_bit] = timeout_flag_n_reg;
        reset_cause_value[wdslp_pkg::rc_pd_bit] = powerdown_flag_n_reg;
    end

    // apb slave, zero wait states
    logic wr_access;
    logic sw_control_hit;
    logic wake_control_hit;
    assign wr_access = psel & penable & pwrite;
    assign sw_control_hit = wr_access & (paddr == wdslp_pkg::addr_sw_control);
    assign wake_control_hit = wr_access & (paddr == wdslp_pkg::addr_wake_control);
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_control_reg <= wdslp_pkg::sw_control_reset;
        end else if (sw_control_hit) begin
            sw_control_reg <= {7'h00, pwdata[wdslp_pkg::sw_enable_bit]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_control_reg <= 8'h00;
        end else if (wake_control_hit) begin
            wake_control_reg <= {7'h00, pwdata[wdslp_pkg::wk_crystal_bit]};
        end
    end

    logic [31:0] read_value;
    always_comb begin
        case (paddr)
            wdslp_pkg::addr_sw_control: read_value = {24'h000000, sw_control_reg};
            wdslp_pkg::addr_reset_cause: read_value = {27'h0, reset_cause_value};
            wdslp_pkg::addr_config_high: read_value = {24'h000000, config_high_value};
            wdslp_pkg::addr_wake_control: read_value = {24'h000000, wake_control_reg};
            default: read_value = 32'h00000000;
        endcase
    end

    // captured in the setup phase so the data stands through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= read_value;
        end
    end
endmodule

// ===== verification/wdslp_checker.sv
`timescale 1ns/10ps
module wdslp_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sleep_instr,
    input wire logic master_clear_pin,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic vector_after_next,
    input wire logic [wdslp_pkg::wake_sources-1:0] irq_flags,
    input wire logic [wdslp_pkg::wake_sources-1:0] irq_enables,
    input wire logic sleeping,
    input wire logic osc_driver_on,
    input wire logic io_hold,
    input wire logic core_stall,
    input wire logic device_reset,
    input wire logic watchdog_reset_pulse
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic pend;
    assign pend = |(irq_flags & irq_enables);
    enter_sleep_a: assert property (sleep_instr && !core_stall && !pend |=> sleeping)
        else $error("sleep not entered");
    pending_nop_a: assert property (sleep_instr && !core_stall && pend |=> !sleeping)
        else $error("sleep not turned into nop");
    osc_off_a: assert property (sleeping |-> !osc_driver_on)
        else $error("oscillator driver on in sleep");
    pins_hold_a: assert property (sleeping |-> io_hold && core_stall)
        else $error("pins or core not held in sleep");
    irq_wake_a: assert property (sleeping && pend && !master_clear_pin |=> !sleeping)
        else $error("enabled interrupt did not wake");
    master_clear_pin_reset_a: assert property (sleeping && master_clear_pin |-> ##[1:2] device_reset)
        else $error("master clear did not reset");
    reset_pulse_a: assert property ($rose(device_reset) |=> !device_reset)
        else $error("device reset longer than one cycle");
    wdt_cause_a: assert property (watchdog_reset_pulse |-> device_reset)
        else $error("watchdog reset without device reset");
    osc_on_a: assert property (!sleeping |-> osc_driver_on)
        else $error("oscillator driver off while awake");
    vector_wake_a: assert property (vector_after_next |-> $past(core_stall))
        else $error("vector without a preceding wake");
    bus_answer_a: assert property (psel && penable |-> pready && !pslverr)
        else $error("register access not answered cleanly");
endmodule
bind wdslp_top wdslp_checker wdslp_chk_i (.pclk, .presetn, .sleep_instr, .master_clear_pin,
    .psel, .penable, .pready, .pslverr, .vector_after_next,
    .irq_flags, .irq_enables, .sleeping, .osc_driver_on, .io_hold, .core_stall, .device_reset,
    .watchdog_reset_pulse);

// ===== verification/wdslp_core_model.sv
`timescale 1ns/10ps
module wdslp_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic core_stall,
    input wire logic want_sleep,
    input wire logic want_clear,
    output logic sleep_instr,
    output logic clear_watchdog_instr
);
    // a stalled core fetches nothing, so no instruction leaves it while held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_instr <= 1'h0;
            clear_watchdog_instr <= 1'h0;
        end else begin
            sleep_instr <= want_sleep && !core_stall && !sleep_instr;
            clear_watchdog_instr <= want_clear && !core_stall;
        end
    end
endmodule

// ===== verification/wdslp_top_tb.sv
`timescale 1ns/10ps
module wdslp_top_tb;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} wdslp_row_type;
    logic pclk, presetn, wdt_rc_clk, psel, penable, pwrite, pready, pslverr, want_sleep;
    logic [7:0] paddr, config_high_value;
    logic [31:0] pwdata, prdata, r;
    logic [wdslp_pkg::wake_sources-1:0] irq_flags, irq_enables;
    logic clear_watchdog_instr, sleep_instr, master_clear_pin, global_interrupt_enable, want_clear;
    logic sleeping, osc_driver_on, io_hold, core_stall, vector_after_next, device_reset;
    logic watchdog_reset_pulse;
    int mismatches, n_compared, n_resets, n_vec, n;
    wdslp_row_type rows [9];
    wdslp_top #(.base_width(3), .startup_cycles(8)) uut (.pclk, .presetn, .wdt_rc_clk, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .config_high_value,
        .clear_watchdog_instr, .sleep_instr, .master_clear_pin, .irq_flags, .irq_enables,
        .global_interrupt_enable, .sleeping, .osc_driver_on, .io_hold, .core_stall,
        .vector_after_next, .device_reset, .watchdog_reset_pulse);
    wdslp_core_model core (.pclk, .presetn, .core_stall, .want_sleep, .want_clear, .sleep_instr,
        .clear_watchdog_instr);
    initial begin
        pclk = 1'h0;
        forever #12.5 pclk = ~pclk;
    end
    // rc clock deliberately unrelated to pclk
    initial begin
        wdt_rc_clk = 1'h0;
        forever #18.5 wdt_rc_clk = ~wdt_rc_clk;
    end
    // pulses are counted here so none is missed between two waits
    always @(posedge pclk) begin
        if (device_reset === 1'h1) n_resets++;
        if (vector_after_next === 1'h1) n_vec++;
    end
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", s, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        r = prdata;
        {psel, penable} <= 2'h0;
    endtask
    task automatic waitv(ref logic s, input logic v);
        for (int i = 0; i < 400 && s !== v; i++) @(posedge pclk);
        if (s !== v) begin
            mismatches++;
            $display("unexpected wait: expected %h seen %h", v, s);
        end
    endtask
    task automatic sleep_now();
        want_sleep <= 1'h1;
        @(posedge pclk);
        want_sleep <= 1'h0;
        repeat (3) @(posedge pclk);
    endtask
    task automatic wake_irq(input logic [31:0] e);
        irq_flags <= 14'h0001;
        waitv(sleeping, 1'h0);
        for (n = 0; n < 2000 && core_stall === 1'h1; n++) @(posedge pclk);
        chk("startup", e, n);
        repeat (4) @(posedge pclk);
        irq_flags <= 14'h0000;
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #200000;
        mismatches++;
        print_verdict();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, irq_flags, irq_enables} = '0;
        {global_interrupt_enable, master_clear_pin, want_sleep, want_clear} = '0;
        config_high_value = 8'h0e;
        rows = '{'{1'h0, 8'h00, 32'h0, 32'h0}, '{1'h1, 8'h00, 32'hff, 32'h0},
            '{1'h0, 8'h00, 32'h0, 32'h1}, '{1'h1, 8'h00, 32'h0, 32'h0},
            '{1'h0, 8'h04, 32'h0, 32'h18}, '{1'h0, 8'h08, 32'h0, 32'h0e},
            '{1'h1, 8'h10, 32'hff, 32'h0}, '{1'h0, 8'h10, 32'h0, 32'h0},
            '{1'h0, 8'h00, 32'h0, 32'h0}};
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk("register", rows[i].e, r);
        end
        config_high_value <= 8'h00;
        {irq_flags, irq_enables} <= {14'h0001, 14'h0001};
        sleep_now();
        chk("nop sleep", 32'h0, sleeping);
        apb(1'h0, 8'h04, 32'h0);
        chk("nop cause", 32'h18, r);
        {irq_flags, global_interrupt_enable} <= {14'h0000, 1'h1};
        sleep_now();
        chk("asleep", 32'h1, sleeping);
        chk("osc off", 32'h0, osc_driver_on);
        apb(1'h0, 8'h04, 32'h0);
        chk("sleep cause", 32'h10, r);
        wake_irq(32'h1);
        chk("vector", 32'h1, n_vec);
        global_interrupt_enable <= 1'h0;
        apb(1'h1, 8'h0c, 32'h1);
        sleep_now();
        wake_irq(32'h9);
        chk("in line", 32'h1, n_vec);
        apb(1'h1, 8'h0c, 32'h0);
        apb(1'h1, 8'h00, 32'h1);
        n = n_resets;
        repeat (40) begin
            want_clear <= 1'h1;
            @(posedge pclk);
            want_clear <= 1'h0;
            repeat (3) @(posedge pclk);
        end
        chk("cleared", n, n_resets);
        sleep_now();
        waitv(sleeping, 1'h0);
        apb(1'h0, 8'h04, 32'h0);
        chk("wake cause", 32'h0, r);
        chk("no reset", n, n_resets);
        config_high_value <= 8'h01;
        apb(1'h1, 8'h00, 32'h0);
        waitv(watchdog_reset_pulse, 1'h1);
        chk("wdt reset", 32'h1, device_reset);
        config_high_value <= 8'h00;
        repeat (4) @(posedge pclk);
        sleep_now();
        master_clear_pin <= 1'h1;
        waitv(device_reset, 1'h1);
        chk("master_clear_pin reset", 32'h1, device_reset);
        chk("master_clear_pin cause", 32'h0, watchdog_reset_pulse);
        master_clear_pin <= 1'h0;
        apb(1'h1, 8'h00, 32'h1);
        sleep_now();
        chk("asleep again", 32'h1, sleeping);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        chk("reset awake", 32'h1, osc_driver_on);
        presetn <= 1'h1;
        apb(1'h0, 8'h04, 32'h0);
        chk("reset cause", 32'h18, r);
        apb(1'h0, 8'h00, 32'h0);
        chk("reset enable", 32'h0, r);
        print_verdict();
    end
endmodule
